// file: src/ditl_pkg.sv
// constants shared by the drive input terminal logic
package ditl_pkg;
  localparam int NUM_TERM = 8;
  localparam int CODE_W = 5;
  localparam int ANA_W = 10;
  localparam int BIP_W = 11;
  localparam int FREQ_W = 13;
  localparam int NUM_FN = 7;
  ////////////////////////////////////////////////////////////////////////////
  // terminal function codes, contiguous from the source toggle upward
  localparam logic [4:0] FN_SOURCE_TOGGLE = 5'h10;
  localparam logic [4:0] FN_TRIP_RESET = 5'h11;
  localparam logic [4:0] FN_RUN_PB = 5'h12;
  localparam logic [4:0] FN_HALT_PB = 5'h13;
  localparam logic [4:0] FN_DIR_SEL = 5'h14;
  localparam logic [4:0] FN_LOOP_DISABLE = 5'h15;
  localparam logic [4:0] FN_INTEG_CLEAR = 5'h16;
  // index of each function in the decoded vectors
  localparam int IDX_TOGGLE = 0;
  localparam int IDX_RESET = 1;
  localparam int IDX_RUN = 2;
  localparam int IDX_HALT = 3;
  localparam int IDX_DIR = 4;
  localparam int IDX_LOOP = 5;
  localparam int IDX_ICLR = 6;
  ////////////////////////////////////////////////////////////////////////////
  // mode settings
  localparam logic ATM_CURRENT = 1'h0;
  localparam logic ATM_BIPOLAR = 1'h1;
  localparam logic [1:0] BIM_NONE = 2'h0;
  localparam logic [1:0] BIM_AUX = 2'h1;
  localparam logic [1:0] BIM_AUX_REV = 2'h2;
  localparam logic [1:0] TCM_ON = 2'h0;
  localparam logic [1:0] TCM_OFF = 2'h1;
  localparam logic [1:0] TCM_ON_ONLY = 2'h2;
  localparam logic RFM_ZERO = 1'h0;
  localparam logic RFM_MATCH = 1'h1;
  localparam logic [1:0] RCS_TERMINAL = 2'h1;
  localparam logic [12:0] FREQ_RST = 13'h0000;
endpackage

// file: src/ditl_func_decode.sv
// decodes one terminal function code into an assigned flag and a level
`timescale 1ns/1ps
module ditl_func_decode #(
  parameter logic [4:0] FUNC_CODE = 5'h00
) (
  input wire logic [ditl_pkg::NUM_TERM-1:0] i_term, // terminal levels
  input wire logic [ditl_pkg::NUM_TERM-1:0][4:0] i_term_func, // code per terminal
  output logic o_level, // any terminal with this code is on
  output logic o_assigned // some terminal carries this code
);
  always_comb begin
    o_level = 1'b0;
    o_assigned = 1'b0;
    for (int t = 0; t < ditl_pkg::NUM_TERM; t++) begin
      if (i_term_func[t] == FUNC_CODE) begin
        o_assigned = 1'b1;
        o_level = o_level | i_term[t];
      end
    end
  end
endmodule // ditl_func_decode

// file: src/ditl_core.sv
// drive input terminal logic: analog source select, trip reset, three-wire run, loop control
`timescale 1ns/1ps
module ditl_core (
  input wire logic i_clk, // 10 MHz clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic [ditl_pkg::NUM_TERM-1:0] i_term, // programmable input levels
  input wire logic [ditl_pkg::NUM_TERM-1:0][4:0] i_term_func, // function code per input
  input wire logic i_forward_run_input, // ordinary forward run
  input wire logic i_reverse_run_input, // ordinary reverse run
  input wire logic [ditl_pkg::ANA_W-1:0] i_unipolar_voltage_input, // unipolar sample
  input wire logic [ditl_pkg::ANA_W-1:0] i_current_loop_input, // current-loop sample
  input wire logic signed [ditl_pkg::BIP_W-1:0] i_bipolar_voltage_input, // bipolar sample
  input wire logic i_analog_toggle_mode, // toggle selects current or bipolar
  input wire logic [1:0] i_bipolar_input_mode, // auxiliary and reverse mode
  input wire logic [1:0] i_trip_clear_mode, // trip clear edge and level mode
  input wire logic i_restart_frequency_mode, // zero or matching restart
  input wire logic [1:0] i_run_command_source, // run command source setting
  input wire logic i_trip_active, // protective trip is present
  input wire logic i_panel_reset_key, // operator panel stop/reset key
  output logic signed [ditl_pkg::FREQ_W-1:0] o_freq_command, // main plus auxiliary
  output logic o_reverse_permitted, // reverse running allowed
  output logic o_run, // drive running
  output logic o_drive_reverse, // direction is reverse
  output logic o_output_cutoff, // output cut off by reset input
  output logic o_trip_clear, // one-cycle trip cancel pulse
  output logic o_restart_match, // restart by frequency matching
  output logic o_pid_enable, // closed loop allowed
  output logic o_integrator_clear // one-cycle integrator clear pulse
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic prev_reset;
    logic prev_key;
    logic prev_run_pb;
    logic prev_iclr;
    logic run_latch;
    logic trip_clear;
    logic iclr_pulse;
    logic cutoff;
    logic restart_match;
    logic [ditl_pkg::FREQ_W-1:0] freq;
    logic rev_perm;
    logic run;
    logic drive_rev;
    logic pid_en;
  } ditl_state_t;

  ditl_state_t state_reg;
  ditl_state_t state_next;

  function automatic logic signed [ditl_pkg::FREQ_W-1:0] ext_u(
    input logic [ditl_pkg::ANA_W-1:0] v);
    ext_u = {3'h0, v};
  endfunction

  function automatic logic signed [ditl_pkg::FREQ_W-1:0] ext_b(
    input logic signed [ditl_pkg::BIP_W-1:0] v);
    ext_b = {{2{v[ditl_pkg::BIP_W-1]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // function decode
  logic [ditl_pkg::NUM_FN-1:0] fn_level;
  logic [ditl_pkg::NUM_FN-1:0] fn_asg;

  for (genvar g = 0; g < ditl_pkg::NUM_FN; g++) begin : g_fn
    // codes 16 to 22 map onto consecutive indices
    ditl_func_decode #(
      .FUNC_CODE(5'(int'(ditl_pkg::FN_SOURCE_TOGGLE) + g))
    ) u_dec (
      .i_term(i_term),
      .i_term_func(i_term_func),
      .o_level(fn_level[g]),
      .o_assigned(fn_asg[g])
    );
  end

  logic tog_asg;
  logic tog_lvl;
  logic rst_lvl;
  logic run_lvl;
  logic halt_asg;
  logic halt_lvl;
  logic dir_lvl;
  logic rst_rise;
  logic rst_fall;
  logic run_rise;
  logic iclr_rise;
  logic key_rise;
  logic tw_en;
  logic rev_perm_c;
  logic signed [ditl_pkg::FREQ_W-1:0] main_c;
  logic signed [ditl_pkg::FREQ_W-1:0] aux_c;
  logic signed [ditl_pkg::FREQ_W-1:0] sum_c;

  assign tog_asg = fn_asg[ditl_pkg::IDX_TOGGLE];
  assign tog_lvl = fn_level[ditl_pkg::IDX_TOGGLE];
  // high level means reset asserted: the input is read as normally open
  assign rst_lvl = fn_level[ditl_pkg::IDX_RESET];
  assign run_lvl = fn_level[ditl_pkg::IDX_RUN];
  assign halt_asg = fn_asg[ditl_pkg::IDX_HALT];
  assign halt_lvl = fn_level[ditl_pkg::IDX_HALT];
  assign dir_lvl = fn_level[ditl_pkg::IDX_DIR];
  assign rst_rise = rst_lvl & ~state_reg.prev_reset;
  assign rst_fall = ~rst_lvl & state_reg.prev_reset;
  assign run_rise = run_lvl & ~state_reg.prev_run_pb;
  assign iclr_rise = fn_level[ditl_pkg::IDX_ICLR] & ~state_reg.prev_iclr;
  assign key_rise = i_panel_reset_key & ~state_reg.prev_key;
  assign tw_en = (i_run_command_source == ditl_pkg::RCS_TERMINAL)
                 & (&fn_asg[ditl_pkg::IDX_DIR:ditl_pkg::IDX_RUN]);

  ////////////////////////////////////////////////////////////////////////////
  // analog source selection
  always_comb begin
    logic main_bip;
    main_bip = 1'b0;
    main_c = ext_u(i_unipolar_voltage_input);
    aux_c = ditl_pkg::FREQ_RST;
    rev_perm_c = 1'b0;
    if (tog_asg) begin
      if (tog_lvl) begin
        if (i_analog_toggle_mode == ditl_pkg::ATM_CURRENT) begin
          main_c = ext_u(i_current_loop_input);
        end else begin
          main_c = ext_b(i_bipolar_voltage_input);
          main_bip = 1'b1;
        end
      end
      // bipolar as main command carries no auxiliary on top
      if ((i_bipolar_input_mode != ditl_pkg::BIM_NONE) && !main_bip) begin
        aux_c = ext_b(i_bipolar_voltage_input);
      end
      rev_perm_c = (i_bipolar_input_mode == ditl_pkg::BIM_AUX_REV)
                   | (main_bip & (i_bipolar_input_mode == ditl_pkg::BIM_NONE));
    end else begin
      if (i_bipolar_input_mode == ditl_pkg::BIM_NONE) begin
        main_c = ext_b(i_bipolar_voltage_input);
        rev_perm_c = 1'b1;
      end else begin
        main_c = ext_u(i_unipolar_voltage_input) + ext_u(i_current_loop_input);
        aux_c = ext_b(i_bipolar_voltage_input);
        rev_perm_c = (i_bipolar_input_mode == ditl_pkg::BIM_AUX_REV);
      end
    end
    sum_c = main_c + aux_c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.prev_reset = rst_lvl;
    state_next.prev_key = i_panel_reset_key;
    state_next.prev_run_pb = run_lvl;
    state_next.prev_iclr = fn_level[ditl_pkg::IDX_ICLR];
    state_next.rev_perm = rev_perm_c;
    // without reverse permission a negative command is held at zero
    if (!rev_perm_c && sum_c < 0) begin
      state_next.freq = ditl_pkg::FREQ_RST;
    end else begin
      state_next.freq = sum_c;
    end

    // trip cancel from panel key or the reset terminal
    state_next.trip_clear = 1'b0;
    if (i_trip_active) begin
      if (key_rise) begin
        state_next.trip_clear = 1'b1;
      end
      if (i_trip_clear_mode == ditl_pkg::TCM_OFF) begin
        if (rst_fall) begin
          state_next.trip_clear = 1'b1;
        end
      end else if (rst_rise) begin
        state_next.trip_clear = 1'b1;
      end
    end
    // in normal operation the reset level cuts off output except in mode 2
    state_next.cutoff = ~i_trip_active & rst_lvl
                        & (i_trip_clear_mode != ditl_pkg::TCM_ON_ONLY);
    if (state_next.trip_clear) begin
      state_next.restart_match = (i_restart_frequency_mode == ditl_pkg::RFM_MATCH);
    end

    // three-wire latch: halt is a break contact, open means stop
    if (!tw_en || !halt_lvl) begin
      state_next.run_latch = 1'b0;
    end else if (run_rise) begin
      state_next.run_latch = 1'b1;
    end
    if (halt_asg) begin
      state_next.run = tw_en & state_next.run_latch;
      state_next.drive_rev = dir_lvl;
    end else if (i_forward_run_input && i_reverse_run_input) begin
      state_next.run = rev_perm_c;
      state_next.drive_rev = rev_perm_c & (sum_c < 0);
    end else begin
      state_next.run = i_forward_run_input | i_reverse_run_input;
      state_next.drive_rev = i_reverse_run_input;
    end

    // closed loop off while its disable input is on
    state_next.pid_en = ~(fn_asg[ditl_pkg::IDX_LOOP] & fn_level[ditl_pkg::IDX_LOOP]);
    state_next.iclr_pulse = iclr_rise;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_freq_command = state_reg.freq;
  assign o_reverse_permitted = state_reg.rev_perm;
  assign o_run = state_reg.run;
  assign o_drive_reverse = state_reg.drive_rev;
  assign o_output_cutoff = state_reg.cutoff;
  assign o_trip_clear = state_reg.trip_clear;
  assign o_restart_match = state_reg.restart_match;
  assign o_pid_enable = state_reg.pid_en;
  assign o_integrator_clear = state_reg.iclr_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_tw_start;
    tw_en & halt_lvl & run_rise;
  endsequence

  sequence s_pulse_once;
    o_integrator_clear ##1 !o_integrator_clear;
  endsequence

  a_clear_on_edge: assert property (
    (i_trip_active && i_trip_clear_mode != ditl_pkg::TCM_OFF && rst_rise) |=> o_trip_clear)
    else $error("trip not cleared on reset rising edge");

  a_clear_off_edge: assert property (
    (i_trip_active && i_trip_clear_mode == ditl_pkg::TCM_OFF && rst_fall) |=> o_trip_clear)
    else $error("trip not cleared on reset falling edge");

  a_normal_cutoff: assert property (
    (!i_trip_active && rst_lvl && i_trip_clear_mode != ditl_pkg::TCM_ON_ONLY)
    |=> o_output_cutoff)
    else $error("reset level did not cut off output");

  a_mode2_ignore: assert property (
    (i_trip_clear_mode == ditl_pkg::TCM_ON_ONLY) |=> !o_output_cutoff)
    else $error("reset level acted in mode 2");

  a_restart_mode: assert property (
    o_trip_clear |-> (o_restart_match == ($past(i_restart_frequency_mode)
                                          == ditl_pkg::RFM_MATCH)))
    else $error("restart mode not captured with trip clear");

  a_loop_disable: assert property (
    (fn_asg[ditl_pkg::IDX_LOOP] && fn_level[ditl_pkg::IDX_LOOP]) |=> !o_pid_enable)
    else $error("closed loop not disabled");

  a_integ_clear: assert property (
    iclr_rise |=> s_pulse_once)
    else $error("integrator clear not a single pulse");

  a_tw_latch: assert property (
    s_tw_start |=> o_run)
    else $error("three-wire run did not latch");

  a_halt_release: assert property (
    (tw_en && !halt_lvl) |=> !o_run)
    else $error("halt did not release run");

  a_fw_rv_ignored: assert property (
    (halt_asg && !tw_en) |=> !o_run)
    else $error("ordinary run acted with halt assigned");

  a_neg_sum_rev: assert property (
    (!halt_asg && rev_perm_c && i_forward_run_input && i_reverse_run_input && sum_c < 0)
    |=> (o_run && o_drive_reverse))
    else $error("negative sum did not drive reverse");

  a_current_sel: assert property (
    (tog_asg && tog_lvl && i_analog_toggle_mode == ditl_pkg::ATM_CURRENT
     && i_bipolar_input_mode == ditl_pkg::BIM_NONE)
    |=> (o_freq_command == {3'h0, $past(i_current_loop_input)}))
    else $error("current-loop input not selected");

  a_unipolar_sel: assert property (
    (tog_asg && !tog_lvl && i_bipolar_input_mode == ditl_pkg::BIM_NONE)
    |=> (o_freq_command == ext_u($past(i_unipolar_voltage_input))))
    else $error("unipolar input not selected");

  a_bipolar_sel: assert property (
    (tog_asg && tog_lvl && i_analog_toggle_mode == ditl_pkg::ATM_BIPOLAR
     && i_bipolar_input_mode == ditl_pkg::BIM_AUX_REV)
    |=> (o_freq_command == ext_b($past(i_bipolar_voltage_input))))
    else $error("bipolar input not selected");

  a_aux_added: assert property (
    (tog_asg && !tog_lvl && i_bipolar_input_mode == ditl_pkg::BIM_AUX_REV)
    |=> (o_reverse_permitted && o_freq_command
         == ext_u($past(i_unipolar_voltage_input)) + ext_b($past(i_bipolar_voltage_input))))
    else $error("bipolar auxiliary not added");

  a_bipolar_alone: assert property (
    (!tog_asg && i_bipolar_input_mode == ditl_pkg::BIM_NONE)
    |=> (o_reverse_permitted && o_freq_command == ext_b($past(i_bipolar_voltage_input))))
    else $error("bipolar input not used alone");

  a_panel_clear: assert property (
    (i_trip_active && key_rise) |=> o_trip_clear)
    else $error("panel key did not clear trip");

  a_clear_needs_trip: assert property (
    !i_trip_active |=> !o_trip_clear)
    else $error("trip clear without a trip");

  a_tw_source: assert property (
    (halt_asg && i_run_command_source != ditl_pkg::RCS_TERMINAL) |=> !o_run)
    else $error("three-wire ran without terminal source");
endmodule // ditl_core

// file: dv/ditl_term_model.sv
// outside contacts driving the programmable terminals
`timescale 1ns/1ps
module ditl_term_model (
  input wire logic [ditl_pkg::NUM_TERM-1:0] i_want, // requested contact states
  output logic [ditl_pkg::NUM_TERM-1:0] o_term // terminal levels seen by the drive
);
  always_comb begin
    // contacts are normally open: closed drives high, open drives low
    o_term = i_want;
    // terminal 6 (integrator clear) passes only while terminal 5 disables the loop
    o_term[6] = i_want[6] & i_want[5];
  end
endmodule // ditl_term_model

// file: dv/drive_input_terminal_logic_tb_top.sv
// self-checking bench for the drive input terminal logic
`timescale 1ns/1ps
module drive_input_terminal_logic_tb_top;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] want;
  logic [7:0] term;
  logic [7:0][4:0] func;
  logic fw, rv, atm, rfm, trip, key;
  logic [9:0] uni, cur;
  logic signed [10:0] bip;
  logic [1:0] bim, tcm, rcs;
  logic signed [12:0] freq;
  logic perm, run, rev, cut, tclr, rmatch, pid, iclr;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed;
  logic [13:0] e;

  always #50 i_clk = ~i_clk;

  ditl_term_model u_model (.i_want(want), .o_term(term));

  ditl_core u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_term(term), .i_term_func(func),
    .i_forward_run_input(fw), .i_reverse_run_input(rv),
    .i_unipolar_voltage_input(uni), .i_current_loop_input(cur),
    .i_bipolar_voltage_input(bip), .i_analog_toggle_mode(atm),
    .i_bipolar_input_mode(bim), .i_trip_clear_mode(tcm),
    .i_restart_frequency_mode(rfm), .i_run_command_source(rcs),
    .i_trip_active(trip), .i_panel_reset_key(key), .o_freq_command(freq),
    .o_reverse_permitted(perm), .o_run(run), .o_drive_reverse(rev),
    .o_output_cutoff(cut), .o_trip_clear(tclr), .o_restart_match(rmatch),
    .o_pid_enable(pid), .o_integrator_clear(iclr)
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // {reverse permitted, expected frequency command}
  function automatic logic [13:0] exp_fp(input logic asg, input logic tog, input logic m,
      input logic [1:0] b, input logic [9:0] u, input logic [9:0] c,
      input logic signed [10:0] x);
    logic signed [12:0] s;
    logic p;
    if (asg) begin
      s = !tog ? 13'(u) : (m == 1'b0 ? 13'(c) : 13'(x));
      if (b != 2'h0 && !(tog && m)) s = s + 13'(x);
      p = (b == 2'h2) || (tog && m && b == 2'h0);
    end else if (b == 2'h0) begin
      s = 13'(x);
      p = 1'b1;
    end else begin
      s = 13'(u) + 13'(c) + 13'(x);
      p = (b == 2'h2);
    end
    if (!p && s < 0) s = 13'h0000;
    return {p, s};
  endfunction

  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic pulse_run();
    want[2] = 1'b1;
    step(1);
    want[2] = 1'b0;
    step(1);
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    want = 8'h08;
    {fw, rv, atm, rfm, trip, key} = 6'h00;
    {uni, cur, bip} = '0;
    {bim, tcm} = 4'h0;
    rcs = 2'h1;
    // terminal k carries the k-th function code, terminal 7 an unused code
    for (int k = 0; k < 7; k++) func[k] = ditl_pkg::FN_SOURCE_TOGGLE + 5'(k);
    func[7] = 5'h00;
    seed = 32'h6FCD;
    step(2);
    chk("run_in_reset", 13'(run), 13'h0000);
    i_rst_b = 1'b1;
    step(1);
    // analog source table with both run inputs on
    func[3] = 5'h00;
    fw = 1'b1;
    rv = 1'b1;
    for (int a = 0; a < 2; a++) for (int t = 0; t < 2; t++) for (int m = 0; m < 2; m++)
      for (int b = 0; b < 3; b++) for (int p = 0; p < 2; p++) begin
        func[0] = a[0] ? ditl_pkg::FN_SOURCE_TOGGLE : 5'h00;
        want[0] = t[0];
        atm = m[0];
        bim = 2'(b);
        if (p == 0) begin
          {uni, cur} = 20'h00000;
          bip = 11'h400;
        end else begin
          seed = xs(seed);
          {cur, uni} = seed[19:0];
          seed = xs(seed);
          bip = seed[10:0];
        end
        e = exp_fp(a[0], t[0], m[0], 2'(b), uni, cur, bip);
        step(1);
        chk("freq", freq, e[12:0]);
        chk("perm", 13'(perm), 13'(e[13]));
        chk("run_both", 13'(run), 13'(e[13]));
        chk("dir_both", 13'(rev), 13'(e[13] & e[12]));
      end
    rv = 1'b0;
    step(1);
    chk("run_fw", 13'(run), 13'h0001);
    func[3] = ditl_pkg::FN_HALT_PB;
    step(1);
    chk("fw_ignored", 13'(run), 13'h0000);
    fw = 1'b0;
    // trip clear modes
    for (int m = 0; m < 3; m++) begin
      tcm = 2'(m);
      rfm = (m == 1);
      trip = 1'b1;
      want[1] = 1'b1;
      step(1);
      chk("clr_on", 13'(tclr), 13'(m != 1));
      step(1);
      chk("clr_pulse", 13'(tclr), 13'h0000);
      want[1] = 1'b0;
      step(1);
      chk("clr_off", 13'(tclr), 13'(m == 1));
      chk("restart", 13'(rmatch), 13'(rfm));
      trip = 1'b0;
      want[1] = 1'b1;
      step(2);
      chk("cutoff", 13'(cut), 13'(m != 2));
      chk("no_clr", 13'(tclr), 13'h0000);
      want[1] = 1'b0;
      step(1);
    end
    trip = 1'b1;
    key = 1'b1;
    step(1);
    chk("panel_clr", 13'(tclr), 13'h0001);
    {trip, key} = 2'h0;
    // three-wire run control
    want[4] = 1'b1;
    pulse_run();
    chk("tw_run", 13'(run), 13'h0001);
    chk("tw_dir", 13'(rev), 13'h0001);
    want[4] = 1'b0;
    step(1);
    chk("tw_fwd", 13'(rev), 13'h0000);
    fw = 1'b1;
    want[3] = 1'b0;
    step(1);
    chk("tw_halt", 13'(run), 13'h0000);
    fw = 1'b0;
    want[3] = 1'b1;
    rcs = 2'h0;
    pulse_run();
    chk("tw_source", 13'(run), 13'h0000);
    rcs = 2'h1;
    func[4] = 5'h00;
    pulse_run();
    chk("tw_partial", 13'(run), 13'h0000);
    func[4] = ditl_pkg::FN_DIR_SEL;
    // closed loop disable and integrator clear
    step(1);
    chk("pid_on", 13'(pid), 13'h0001);
    want[5] = 1'b1;
    step(1);
    chk("pid_off", 13'(pid), 13'h0000);
    want[6] = 1'b1;
    step(1);
    chk("iclr_pulse", 13'(iclr), 13'h0001);
    step(1);
    chk("iclr_end", 13'(iclr), 13'h0000);
    conclude();
  end
endmodule // drive_input_terminal_logic_tb_top
